// ==== testbench/hca_thermostat.sv ====
// ----------------------------------------
// Thermostat sending control telegrams
// ----------------------------------------
module hca_thermostat
    import hca_pkg::*;
#(
    parameter int PERIOD = 90
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic send,
    input wire logic cyclic,
    input wire logic [2:0] kind,
    input wire logic [7:0] value,
    output logic tel_valid,
    output logic [2:0] tel_kind,
    output logic [7:0] tel_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic fire;
    // Repeats well inside a third of the timeout
    assign fire = send | (cyclic & (cnt_r == 8'(PERIOD - 1)));
    // Idle data toggles, so a stale value never looks valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            {cnt_r, tel_valid, tel_kind, tel_value} <= '0;
        else
            {cnt_r, tel_valid, tel_kind, tel_value} <= {fire ? 8'h00 : cnt_r + 8'h01, fire, kind,
                fire ? value : ~tel_value};
    end
endmodule : hca_thermostat

// ==== testbench/test_hca_arbiter.sv ====
module test_hca_arbiter
    import hca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [8:0] ctrl; logic [2:0] kind; logic [7:0] val;
        logic [6:0] heat; logic [6:0] cool; logic [6:0] fan; logic heating;} hca_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0, cyclic = 1'b0;
    logic fault_req = 1'b0, bus_recover = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0, kind = '0, tel_kind;
    logic [7:0] value = '0, tel_value;
    logic hreadyout, hresp, tel_valid, heat_pwm, cool_pwm, heating, fault, emergency, fault_send;
    logic [6:0] heat_valve, cool_valve, fan_demand;
    int miscompares = 0, comparisons = 0, n, hi;
    hca_row_t r;
    hca_row_t rows[14] = '{
        '{9'h058, 3'h0, 8'h32, 7'h32, 7'h00, 7'h32, 1'b1}, '{9'h058, 3'h1, 8'h28, 7'h00, 7'h28, 7'h28, 1'b0},
        '{9'h058, 3'h0, 8'h00, 7'h00, 7'h28, 7'h28, 1'b0}, '{9'h058, 3'h0, 8'h78, 7'h64, 7'h00, 7'h64, 1'b1},
        '{9'h054, 3'h1, 8'h1E, 7'h1E, 7'h00, 7'h1E, 1'b0}, '{9'h054, 3'h0, 8'h3C, 7'h3C, 7'h00, 7'h3C, 1'b1},
        '{9'h052, 3'h2, 8'h46, 7'h46, 7'h00, 7'h46, 1'b1}, '{9'h052, 3'h4, 8'h00, 7'h00, 7'h46, 7'h46, 1'b0},
        '{9'h052, 3'h4, 8'h01, 7'h46, 7'h00, 7'h46, 1'b1}, '{9'h056, 3'h1, 8'h19, 7'h19, 7'h00, 7'h19, 1'b1},
        '{9'h056, 3'h4, 8'h00, 7'h19, 7'h00, 7'h19, 1'b0}, '{9'h050, 3'h2, 8'h2D, 7'h2D, 7'h00, 7'h2D, 1'b0},
        '{9'h050, 3'h3, 8'h14, 7'h2D, 7'h14, 7'h2D, 1'b0}, '{9'h050, 3'h4, 8'h01, 7'h2D, 7'h14, 7'h2D, 1'b0}};
    logic [7:0] ra[5] = '{ADDR_CTRL, ADDR_TIMEOUT, ADDR_FAULT_VAL, ADDR_PWM_CYCLE, 8'h18};
    logic [31:0] re[5] = '{32'h50, 32'h78, 32'h1E, 32'hB4, 32'h0};
    logic [8:0] rc[3] = '{9'h0D8, 9'h158, 9'h058};

    // Short seconds tick keeps the timeout run brief
    hca_arbiter #(.TICK_CYCLES(10)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tel_valid, .tel_kind, .tel_value, .fault_req,
        .bus_recover, .heat_valve, .cool_valve, .fan_demand, .heat_pwm, .cool_pwm, .heating, .fault,
        .emergency, .fault_send);
    hca_thermostat u_tst (.hclk, .hresetn, .send, .cyclic, .kind, .value, .tel_valid, .tel_kind, .tel_value);

    // 200 MHz clock
    always #2.5 hclk = ~hclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // Bounded wait on a condition sampled at each rising edge
    task automatic wait_on(input int s, input int lim, output int c);
        c = 0;
        while (s == 0 ? emergency !== 1'b1 : hreadyout !== 1'b1)
        begin
            c++;
            if (c > lim)
            begin
                miscompares++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask : wait_on
    // Single word transfer; the slave may stretch either phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, a, w, HSIZE_WORD};
        @(posedge hclk);
        wait_on(1, 20, n);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge hclk);
        wait_on(1, 20, n);
        rd = hrdata;
    endtask : ahb
    task automatic tel(input logic [2:0] k, input logic [7:0] v);
        {send, kind, value} <= {1'b1, k, v};
        @(posedge hclk);
        send <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : tel
    // Counts fault status sends after one request
    task automatic ask(output int c);
        fault_req <= 1'b1;
        @(posedge hclk);
        fault_req <= 1'b0;
        c = 0;
        repeat (5) @(posedge hclk) c += (fault_send === 1'b1);
    endtask : ask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("reset", 10'h200, {heating, fault, emergency, heat_valve});
        foreach (ra[i])
        begin
            ahb(1'b0, ra[i], 32'h0);
            chk("reg", re[i], rd);
        end
        ahb(1'b1, ADDR_TIMEOUT, 32'h5);
        ahb(1'b0, ADDR_TIMEOUT, 32'h0);
        chk("timeout", 32'h1E, rd);
        ahb(1'b1, ADDR_FAULT_VAL, 32'h78);
        ahb(1'b0, ADDR_FAULT_VAL, 32'h0);
        chk("fault val", 32'h64, rd);
        foreach (rows[i])
        begin
            r = rows[i];
            ahb(1'b1, ADDR_CTRL, {23'h0, r.ctrl});
            tel(r.kind, r.val);
            chk("drive", {r.heat, r.cool, r.fan, r.heating}, {heat_valve, cool_valve, fan_demand, heating});
        end
        $display("mode table done");
        // Dropping a mode closes the valve it no longer uses
        ahb(1'b1, ADDR_CTRL, 32'h54);
        repeat (2) @(posedge hclk);
        chk("unused cool", 7'h00, cool_valve);
        ahb(1'b1, ADDR_CTRL, 32'h5A);
        repeat (2) @(posedge hclk);
        chk("bad mode", 14'h0, {heat_valve, cool_valve});
        foreach (rc[i])
        begin
            ahb(1'b1, ADDR_CTRL, {23'h0, rc[i]});
            bus_recover <= 1'b1;
            @(posedge hclk);
            bus_recover <= 1'b0;
            repeat (2) @(posedge hclk);
            chk("recover", i == 0, heating);
        end
        $display("mode change and recovery done");
        ahb(1'b1, ADDR_FAULT_VAL, 32'h28);
        ahb(1'b1, ADDR_PWM_CYCLE, 32'h0A);
        ahb(1'b1, ADDR_CTRL, 32'h59);
        cyclic <= 1'b1;
        tel(3'h0, 8'h32);
        repeat (700) @(posedge hclk);
        chk("alive", 1'b0, fault);
        cyclic <= 1'b0;
        tel(3'h0, 8'h32);
        wait_on(0, 400, n);
        chk("expiry", 1'b1, n > 270 && n < 305);
        chk("fault sent", 1'b1, fault_send);
        chk("emergency", 10'h350, {fault, emergency, heat_valve, cool_pwm});
        hi = 0;
        repeat (100) @(posedge hclk) hi += (heat_pwm === 1'b1);
        chk("pwm", 40, hi);
        ask(hi);
        chk("no send", 0, hi);
        ahb(1'b1, ADDR_CTRL, 32'h69);
        ask(hi);
        chk("req send", 1, hi);
        ahb(1'b1, ADDR_CTRL, 32'h79);
        ask(hi);
        chk("both send", 1, hi);
        tel(3'h0, 8'h3C);
        chk("recovered", 10'h078, {fault, emergency, heat_valve, heat_pwm});
        ahb(1'b1, ADDR_CTRL, 32'h58);
        repeat (400) @(posedge hclk);
        chk("no watch", 1'b0, fault);
        $display("supervision done");
        // Mid-run reset must drop mode and drive back to defaults
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("mid reset", 10'h200, {heating, fault, emergency, heat_valve});
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("mid reset ctrl", 32'h50, rd);
        $display("mid-run reset done");
        final_report();
    end
endmodule : test_hca_arbiter

// ==== verilog/hca_arbiter.sv ====
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
module hca_arbiter
    import hca_pkg::*;
#(
    parameter int TICK_CYCLES = SEC_CYCLES,
    parameter int PWM_W = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic tel_valid,
    input wire logic [2:0] tel_kind,
    input wire logic [7:0] tel_value,
    input wire logic fault_req,
    input wire logic bus_recover,
    output logic [6:0] heat_valve,
    output logic [6:0] cool_valve,
    output logic [6:0] fan_demand,
    output logic heat_pwm,
    output logic cool_pwm,
    output logic heating,
    output logic fault,
    output logic emergency,
    output logic fault_send
);

    typedef struct packed {
        logic mon;
        hca_mode_t mode;
        hca_send_t send;
        logic pol;
        hca_rec_t rec;
        logic [15:0] timeout;
        logic [6:0] fault_val;
        logic [PWM_W-1:0] pwm_cycle;
        logic [15:0] timer;
        logic fault;
        logic emerg;
        logic fault_send;
        logic heating;
        logic [6:0] comb_cmd;
        logic [6:0] extra_cmd;
        logic [6:0] heat_cmd;
        logic [6:0] cool_cmd;
        logic [6:0] last_cmd;
        logic [6:0] heat_valve;
        logic [6:0] cool_valve;
        logic [6:0] fan;
        logic ap_wr;
        logic rd_pend;
        logic [7:0] ap_addr;
        logic hreadyout;
        logic [31:0] hrdata;
    } hca_state_t;

    hca_state_t st_r;
    hca_state_t st_nxt;
    logic tick;
    logic take;
    logic mon_tel;
    logic is_heat;
    logic auto_mode;
    logic sw_mode;
    logic two_pipe;
    logic [6:0] pct;
    logic heat_pwm_en;
    logic cool_pwm_en;
    hca_tel_t kind;

    // ------------------------------------------------------------
    // Seconds tick and emergency PWM
    // ------------------------------------------------------------
    hca_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // Only the valve that is active in the current mode pulses
    assign heat_pwm_en = st_r.emerg && (st_r.mode != MODE_2V4P && st_r.mode != MODE_1V4P_SW || st_r.heating);
    assign cool_pwm_en = st_r.emerg && (st_r.mode == MODE_2V4P || st_r.mode == MODE_1V4P_SW) && !st_r.heating;

    hca_pwm #(
        .W(PWM_W)
    ) u_heat_pwm (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .en(heat_pwm_en),
        .cycle_s(st_r.pwm_cycle),
        .duty(st_r.fault_val),
        .pwm(heat_pwm)
    );

    hca_pwm #(
        .W(PWM_W)
    ) u_cool_pwm (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .en(cool_pwm_en),
        .cycle_s(st_r.pwm_cycle),
        .duty(st_r.fault_val),
        .pwm(cool_pwm)
    );

    // ------------------------------------------------------------
    // Decoded telegram and mode flags
    // ------------------------------------------------------------
    assign kind = hca_tel_t'(tel_kind);
    assign take = hsel && htrans[1] && hready;
    assign mon_tel = tel_valid && (kind == TEL_HEAT || kind == TEL_COOL || kind == TEL_COMBINED);
    assign is_heat = (kind == TEL_HEAT);
    assign auto_mode = (st_r.mode == MODE_2V2P) || (st_r.mode == MODE_2V4P);
    assign sw_mode = (st_r.mode == MODE_1V4P_SW) || (st_r.mode == MODE_2V2P_SW);
    assign two_pipe = (st_r.mode == MODE_2V2P) || (st_r.mode == MODE_2V2P_SW);
    // Values above full scale saturate rather than wrap
    assign pct = (tel_value > {1'b0, PCT_FULL}) ? PCT_FULL : tel_value[6:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.fault_send = 1'b0;
        st_nxt.hreadyout = 1'b1;
        // Write data phase commits hwdata to the address captured last cycle
        if (st_r.ap_wr)
        begin
            if (st_r.ap_addr == ADDR_CTRL)
            begin
                st_nxt.mon = hwdata[CTRL_MON_BIT];
                st_nxt.mode = hca_mode_t'(hwdata[CTRL_MODE_LSB +: 3]);
                st_nxt.send = hca_send_t'(hwdata[CTRL_SEND_LSB +: 2]);
                st_nxt.pol = hwdata[CTRL_POL_BIT];
                st_nxt.rec = hca_rec_t'(hwdata[CTRL_REC_LSB +: 2]);
            end
            else if (st_r.ap_addr == ADDR_TIMEOUT)
                st_nxt.timeout = (hwdata[15:0] < TIMEOUT_MIN) ? TIMEOUT_MIN : hwdata[15:0];
            else if (st_r.ap_addr == ADDR_FAULT_VAL)
                st_nxt.fault_val = (hwdata[7:0] > {1'b0, PCT_FULL}) ? PCT_FULL : hwdata[6:0];
            else if (st_r.ap_addr == ADDR_PWM_CYCLE)
                st_nxt.pwm_cycle = hwdata[PWM_W-1:0];
        end
        // Read costs one wait state so hrdata leaves a flop
        st_nxt.ap_wr = 1'b0;
        st_nxt.rd_pend = 1'b0;
        if (st_r.rd_pend)
        begin
            st_nxt.hrdata = 32'h0;
            if (st_r.ap_addr == ADDR_CTRL)
                st_nxt.hrdata = 32'({st_r.rec, st_r.pol, st_r.send, st_r.mode, st_r.mon});
            else if (st_r.ap_addr == ADDR_TIMEOUT)
                st_nxt.hrdata = 32'(st_r.timeout);
            else if (st_r.ap_addr == ADDR_FAULT_VAL)
                st_nxt.hrdata = 32'(st_r.fault_val);
            else if (st_r.ap_addr == ADDR_PWM_CYCLE)
                st_nxt.hrdata = 32'(st_r.pwm_cycle);
            else if (st_r.ap_addr == ADDR_STATUS)
                st_nxt.hrdata = 32'({st_r.timer, 13'h0, st_r.emerg, st_r.heating, st_r.fault});
            else if (st_r.ap_addr == ADDR_DRIVE)
                st_nxt.hrdata = 32'({st_r.fan, 1'b0, st_r.cool_valve, 1'b0, st_r.heat_valve});
        end
        else if (take)
        begin
            st_nxt.ap_addr = haddr[7:0];
            st_nxt.ap_wr = hwrite && (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h0);
            st_nxt.rd_pend = !hwrite;
            st_nxt.hreadyout = hwrite;
        end

        // Control value telegrams
        if (tel_valid)
        begin
            case (kind)
                TEL_COMBINED: st_nxt.comb_cmd = pct;
                TEL_COOL_EXTRA: st_nxt.extra_cmd = pct;
                TEL_TOGGLE:
                begin
                    if (sw_mode)
                        st_nxt.heating = (tel_value[0] == st_r.pol);
                end
                TEL_HEAT, TEL_COOL:
                begin
                    st_nxt.last_cmd = pct;
                    if (pct != 7'h0)
                    begin
                        st_nxt.heat_cmd = is_heat ? pct : 7'h0;
                        st_nxt.cool_cmd = is_heat ? 7'h0 : pct;
                        if (auto_mode)
                            st_nxt.heating = is_heat;
                    end
                    else if (is_heat && st_r.cool_cmd == 7'h0)
                        st_nxt.heat_cmd = 7'h0;
                    else if (!is_heat && st_r.heat_cmd == 7'h0)
                        st_nxt.cool_cmd = 7'h0;
                end
                default:
                begin
                end
            endcase
        end

        // Bus voltage recovery
        if (bus_recover)
        begin
            st_nxt.timer = 16'h0;
            if (st_r.rec == REC_HEAT)
                st_nxt.heating = 1'b1;
            else if (st_r.rec == REC_COOL)
                st_nxt.heating = 1'b0;
        end

        // Supervision; a heat, cool or combined telegram proves the link alive so it beats expiry
        if (!st_r.mon)
        begin
            st_nxt.timer = 16'h0;
            st_nxt.fault = 1'b0;
            st_nxt.emerg = 1'b0;
        end
        else if (mon_tel)
        begin
            st_nxt.timer = 16'h0;
            st_nxt.fault = 1'b0;
            st_nxt.emerg = 1'b0;
        end
        else if (tick && !st_r.fault)
        begin
            if (17'(st_r.timer) + 17'h1 >= 17'(st_r.timeout))
            begin
                st_nxt.fault = 1'b1;
                st_nxt.emerg = 1'b1;
            end
            else
                st_nxt.timer = st_r.timer + 16'h1;
        end

        // Fault status transmission request
        if ((st_nxt.fault != st_r.fault) && (st_r.send == SEND_CHANGE || st_r.send == SEND_BOTH))
            st_nxt.fault_send = 1'b1;
        if (fault_req && (st_r.send == SEND_REQUEST || st_r.send == SEND_BOTH))
            st_nxt.fault_send = 1'b1;

        // Valve and fan drive; unused valves closed, no curve applied
        st_nxt.heat_valve = 7'h0;
        st_nxt.cool_valve = 7'h0;
        st_nxt.fan = 7'h0;
        case (st_nxt.mode)
            MODE_1V2P:
            begin
                st_nxt.heat_valve = st_nxt.emerg ? st_nxt.fault_val : st_nxt.comb_cmd;
                st_nxt.cool_valve = st_nxt.extra_cmd;
                st_nxt.fan = st_nxt.heat_valve;
            end
            MODE_1V4P_SW:
            begin
                st_nxt.fan = st_nxt.emerg ? st_nxt.fault_val : st_nxt.comb_cmd;
                if (st_nxt.heating)
                    st_nxt.heat_valve = st_nxt.fan;
                else
                    st_nxt.cool_valve = st_nxt.fan;
            end
            MODE_2V2P:
            begin
                st_nxt.heat_valve = st_nxt.heating ? st_nxt.heat_cmd : st_nxt.cool_cmd;
                if (st_nxt.emerg)
                    st_nxt.heat_valve = st_nxt.fault_val;
                st_nxt.fan = st_nxt.heat_valve;
            end
            MODE_2V2P_SW:
            begin
                st_nxt.heat_valve = st_nxt.emerg ? st_nxt.fault_val : st_nxt.last_cmd;
                st_nxt.fan = st_nxt.heat_valve;
            end
            MODE_2V4P:
            begin
                st_nxt.fan = st_nxt.heating ? st_nxt.heat_cmd : st_nxt.cool_cmd;
                if (st_nxt.emerg)
                    st_nxt.fan = st_nxt.fault_val;
                if (st_nxt.heating)
                    st_nxt.heat_valve = st_nxt.fan;
                else
                    st_nxt.cool_valve = st_nxt.fan;
            end
            default:
            begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
            st_r.send <= SEND_CHANGE;
            st_r.pol <= 1'b1;
            st_r.timeout <= TIMEOUT_DEF;
            st_r.fault_val <= FAULT_VAL_DEF;
            st_r.pwm_cycle <= PWM_W'(PWM_CYCLE_DEF);
            st_r.heating <= 1'b1;
            st_r.hreadyout <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs
    assign hreadyout = st_r.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_r.hrdata;
    assign heat_valve = st_r.heat_valve;
    assign cool_valve = st_r.cool_valve;
    assign fan_demand = st_r.fan;
    assign heating = st_r.heating;
    assign fault = st_r.fault;
    assign emergency = st_r.emerg;
    assign fault_send = st_r.fault_send;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_monitor_off_quiet: assert property (!st_r.mon |=> !st_r.fault && !st_r.emerg && st_r.timer == 16'h0)
        else $error("fault raised with monitoring off");
    a_timer_restart: assert property (st_r.mon && mon_tel |=> st_r.timer == 16'h0)
        else $error("supervision timer not restarted");
    a_timeout_fault: assert property (st_r.mon && !mon_tel && tick && !st_r.fault
        && (17'(st_r.timer) + 17'h1 >= 17'(st_r.timeout)) |=> st_r.fault && st_r.emerg)
        else $error("timeout did not raise fault");
    a_emerg_value: assert property (st_r.emerg && st_r.mode <= MODE_2V4P |-> st_r.fan == st_r.fault_val)
        else $error("emergency value not substituted");
    a_pwm_idle: assert property (!st_r.emerg |=> !heat_pwm && !cool_pwm)
        else $error("pwm active outside emergency");
    a_send_change: assert property (st_r.fault != $past(st_r.fault) && $past(st_r.send) == SEND_CHANGE
        |-> st_r.fault_send)
        else $error("fault change not sent");
    a_toggle_heat: assert property (tel_valid && kind == TEL_TOGGLE && sw_mode && !bus_recover
        && tel_value[0] == st_r.pol |=> st_r.heating)
        else $error("toggle did not select heating");
    a_toggle_cool: assert property (tel_valid && kind == TEL_TOGGLE && sw_mode && !bus_recover
        && tel_value[0] != st_r.pol |=> !st_r.heating)
        else $error("toggle did not select cooling");
    a_two_pipe_cool: assert property (two_pipe |-> st_r.cool_valve == 7'h0)
        else $error("cool valve driven in two pipe mode");
    a_other_closed: assert property (st_r.mode == MODE_2V4P && st_r.heat_valve != 7'h0
        |-> st_r.cool_valve == 7'h0)
        else $error("both valves open");
    a_tel_clears: assert property (st_r.mon && mon_tel |=> !st_r.fault && !st_r.emerg)
        else $error("telegram did not clear fault");

endmodule : hca_arbiter

// ==== verilog/hca_pkg.sv ====
package hca_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses of the AHB-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
    localparam logic [7:0] ADDR_FAULT_VAL = 8'h08;
    localparam logic [7:0] ADDR_PWM_CYCLE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DRIVE = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_MON_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SEND_LSB = 4;
    localparam int CTRL_POL_BIT = 6;
    localparam int CTRL_REC_LSB = 7;
    localparam int DRIVE_COOL_LSB = 8;
    localparam int DRIVE_FAN_LSB = 16;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] TIMEOUT_MIN = 16'h001E;
    localparam logic [15:0] TIMEOUT_DEF = 16'h0078;
    localparam logic [6:0] FAULT_VAL_DEF = 7'h1E;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [15:0] PWM_CYCLE_DEF = 16'h00B4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // Timing: one supervision tick per second
    // ------------------------------------------------------------
    localparam int SECOND_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {MODE_1V2P, MODE_1V4P_SW, MODE_2V2P, MODE_2V2P_SW, MODE_2V4P} hca_mode_t;
    typedef enum logic [1:0] {SEND_NEVER, SEND_CHANGE, SEND_REQUEST, SEND_BOTH} hca_send_t;
    typedef enum logic [1:0] {REC_KEEP, REC_HEAT, REC_COOL, REC_SPARE} hca_rec_t;
    typedef enum logic [2:0] {TEL_HEAT, TEL_COOL, TEL_COMBINED, TEL_COOL_EXTRA, TEL_TOGGLE} hca_tel_t;

endpackage : hca_pkg

// ==== verilog/hca_pwm.sv ====
// Slow PWM on the seconds tick, duty in percent of the cycle
module hca_pwm
    import hca_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic en,
    input wire logic [W-1:0] cycle_s,
    input wire logic [6:0] duty,
    output logic pwm
);

    typedef struct packed {
        logic [W-1:0] phase;
        logic out;
    } hca_pwm_t;

    hca_pwm_t st_r;
    hca_pwm_t st_nxt;
    logic [W+6:0] lhs;
    logic [W+6:0] rhs;

    // --------------------------------------------------------
    // Phase counter and compare
    // --------------------------------------------------------
    // Products stay inside W+7 bits since duty never exceeds 100
    always_comb
    begin
        st_nxt = st_r;
        lhs = (W+7)'(st_r.phase) * (W+7)'(PCT_FULL);
        rhs = (W+7)'(duty) * (W+7)'(cycle_s);
        if (!en)
            st_nxt.phase = '0;
        else if (tick)
            st_nxt.phase = ((W+1)'(st_r.phase) + (W+1)'(1) >= (W+1)'(cycle_s)) ? '0 : st_r.phase + W'(1);
        st_nxt.out = en && (lhs < rhs);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pwm = st_r.out;

endmodule : hca_pwm

// ==== verilog/hca_tick.sv ====
// Seconds strobe from the system clock
module hca_tick
    import hca_pkg::*;
#(
    parameter int CYCLES = SEC_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } hca_tick_t;

    hca_tick_t st_r;
    hca_tick_t st_nxt;

    // --------------------------------------------------------
    // Free running divider
    // --------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt >= 32'(CYCLES - 1))
        begin
            st_nxt.cnt = 32'h0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

endmodule : hca_tick
